// >>> rtl/hms_defines.svh
// object indices, field positions, method codes and reset values of the homing sequencer
`ifndef HMS_DEFINES_SVH
`define HMS_DEFINES_SVH
`define HMS_IDX_TOUCH_CTRL   16'h60b8
`define HMS_IDX_METHOD       16'h6098
`define HMS_IDX_STATUS       16'h2000
`define HMS_IDX_POSITION     16'h2001
`define HMS_TOUCH_CTRL_RST   16'h0000
`define HMS_METHOD_RST       8'h00
`define HMS_METHOD_MAX       8'h23
`define HMS_CODE_COINC_LO    8'h11
`define HMS_CODE_COINC_HI    8'h1e
`define HMS_CODE_COINC_OFS   8'h10
`define HMS_CODE_IDX_NEG     8'h21
`define HMS_CODE_IDX_POS     8'h22
`define HMS_CODE_HERE        8'h23
`define HMS_ST_BUSY_BIT      0
`define HMS_ST_DONE_BIT      1
`define HMS_ST_ERR_BIT       2
`define HMS_ST_SLOW_BIT      3
`define HMS_ST_POS_BIT       4
`define HMS_ST_NEG_BIT       5
`define HMS_EDGE_WIDTH       4
`define HMS_IN_NLIM          0
`define HMS_IN_PLIM          1
`define HMS_IN_HSW           2
`define HMS_IN_INDEX         3
`endif

// >>> rtl/hms_pkg.sv
// types shared by the homing sequencer files
package hms_pkg;
  typedef enum logic [1:0] {
    HMS_REF_NONE,
    HMS_REF_NLIM,
    HMS_REF_PLIM,
    HMS_REF_HSW
  } hms_ref_t;
  typedef enum logic [2:0] {
    HMS_ST_IDLE,
    HMS_ST_SEEK,
    HMS_ST_CREEP,
    HMS_ST_DONE,
    HMS_ST_FAULT
  } hms_state_t;
  typedef struct packed {
    logic     valid;
    logic     moves;
    logic     dir_pos;
    hms_ref_t ref_sel;
    logic     edge_rise;
    logic     other_side;
    logic     use_index;
  } hms_plan_t;
endpackage

// >>> rtl/hms_edge_det.sv
// registered rising and falling edge detector for the switch and index inputs
`timescale 1ns/1ns
`default_nettype none
module hms_edge_det #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] level,
  output var  logic [WIDTH-1:0] rise,
  output var  logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] prev_reg;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          prev_reg[i] <= 1'b0;
          level[i]    <= 1'b0;
          rise[i]     <= 1'b0;
          fall[i]     <= 1'b0;
        end else begin
          prev_reg[i] <= din[i];
          level[i]    <= din[i];
          rise[i]     <= din[i] & ~prev_reg[i];
          fall[i]     <= ~din[i] & prev_reg[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// >>> rtl/hms_sequencer.sv
// homing method sequencer: method decode, search state machine, origin count, object access
// Overview of operation
// RULE1: code 1: negative, negative limit fall, index
// RULE2: code 2: positive, positive limit fall, index
// RULE3: codes 3,5,7,11: switch falling edge, index
// RULE4: codes 4,6,8,12: switch rising edge, index
// RULE5: codes 9,13: far-side rising edge, index
// RULE6: codes 10,14: far-side falling edge, index
// RULE7: codes 17-30: home on the switch edge
// RULE8: code 33: negative search, next index homes
// RULE9: code 34: positive search, next index homes
// RULE10: code 35: no motion, present position homes
// RULE11: on home stop and zero position count
`include "hms_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module hms_sequencer (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        neg_limit,
  input  wire logic        pos_limit,
  input  wire logic        home_switch,
  input  wire logic        enc_index,
  input  wire logic        enc_step,
  input  wire logic        enc_dir_pos,
  input  wire logic        homing_start,
  input  wire logic        homing_abort,
  input  wire logic        obj_sel,
  input  wire logic        obj_wr,
  input  wire logic [15:0] obj_index,
  input  wire logic [15:0] obj_wdata,
  output var  logic [31:0] obj_rdata,
  output var  logic        obj_ack,
  output var  logic        obj_err,
  output var  logic        move_pos,
  output var  logic        move_neg,
  output var  logic        move_slow,
  output var  logic        homing_busy,
  output var  logic        homing_done,
  output var  logic        homing_error,
  output var  logic        home_set,
  output var  logic [31:0] position
);
  // two-stage release; assertion is immediate, release follows the clock
  logic rst_s1_reg, rst_sync_n;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_reg <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_sync_n <= rst_s1_reg;
    end
  end

  logic [`HMS_EDGE_WIDTH-1:0] in_lvl, in_rise, in_fall;
  hms_edge_det #(.WIDTH(`HMS_EDGE_WIDTH)) u_edges (
    .clk   (clk),
    .rst_n (rst_sync_n),
    .din   ({enc_index, home_switch, pos_limit, neg_limit}),
    .level (in_lvl),
    .rise  (in_rise),
    .fall  (in_fall)
  );

  function automatic hms_pkg::hms_plan_t plan_of(input logic [7:0] code);
    hms_pkg::hms_plan_t p;
    logic               coinc;
    logic [7:0]         base;
    p = '0;
    coinc = (code >= `HMS_CODE_COINC_LO) && (code <= `HMS_CODE_COINC_HI);
    base = coinc ? code - `HMS_CODE_COINC_OFS : code;
    p.moves = 1'b1;
    p.use_index = ~coinc; // [RULE7]
    p.ref_sel = hms_pkg::HMS_REF_HSW;
    case (base)
      8'h01: begin p.valid = 1'b1; p.ref_sel = hms_pkg::HMS_REF_NLIM; end // [RULE1]
      8'h02: begin p.valid = 1'b1; p.dir_pos = 1'b1; p.ref_sel = hms_pkg::HMS_REF_PLIM; end // [RULE2]
      8'h03, 8'h07: begin p.valid = 1'b1; p.dir_pos = 1'b1; end // [RULE3]
      8'h05, 8'h0b: p.valid = 1'b1; // [RULE3]
      8'h06, 8'h08: begin p.valid = 1'b1; p.dir_pos = 1'b1; p.edge_rise = 1'b1; end // [RULE4]
      8'h04, 8'h0c: begin p.valid = 1'b1; p.edge_rise = 1'b1; end // [RULE4]
      8'h09: begin p.valid = 1'b1; p.dir_pos = 1'b1; p.edge_rise = 1'b1; p.other_side = 1'b1; end // [RULE5]
      8'h0d: begin p.valid = 1'b1; p.edge_rise = 1'b1; p.other_side = 1'b1; end // [RULE5]
      8'h0a: begin p.valid = 1'b1; p.dir_pos = 1'b1; p.other_side = 1'b1; end // [RULE6]
      8'h0e: begin p.valid = 1'b1; p.other_side = 1'b1; end // [RULE6]
      `HMS_CODE_IDX_NEG: begin p.valid = 1'b1; p.ref_sel = hms_pkg::HMS_REF_NONE; end // [RULE8]
      `HMS_CODE_IDX_POS: begin p.valid = 1'b1; p.dir_pos = 1'b1; p.ref_sel = hms_pkg::HMS_REF_NONE; end // [RULE9]
      `HMS_CODE_HERE: begin
        p.valid = 1'b1; p.moves = 1'b0; p.use_index = 1'b0; p.ref_sel = hms_pkg::HMS_REF_NONE; // [RULE10]
      end
      default: p.valid = 1'b0;
    endcase
    return p;
  endfunction

  hms_pkg::hms_state_t state_reg, state_next;
  hms_pkg::hms_plan_t  plan_reg;
  logic [7:0]          method_reg, method_act_reg;
  logic [15:0]         touch_ctrl_reg;
  logic                seen_reg;

  // the reference level and edges seen by the search for the latched plan
  wire hms_pkg::hms_plan_t plan_new = plan_of(method_reg);
  wire [1:0] ref_idx    = plan_reg.ref_sel == hms_pkg::HMS_REF_NLIM ? 2'(`HMS_IN_NLIM) :
                          plan_reg.ref_sel == hms_pkg::HMS_REF_PLIM ? 2'(`HMS_IN_PLIM) : 2'(`HMS_IN_HSW);
  wire       ref_level  = in_lvl[ref_idx];
  wire       ref_edge   = plan_reg.edge_rise ? in_rise[ref_idx] : in_fall[ref_idx];
  // far-side edges count only once the switch has been crossed into
  wire       ref_hit    = ref_edge & (~plan_reg.other_side | seen_reg); // [RULE5] [RULE6]
  wire       index_hit  = in_rise[`HMS_IN_INDEX];
  // running onto the limit in the travel direction while not searching for it is a fault
  wire       lim_ahead  = plan_reg.dir_pos ? in_lvl[`HMS_IN_PLIM] : in_lvl[`HMS_IN_NLIM];
  wire       lim_fault  = lim_ahead & (plan_reg.ref_sel == hms_pkg::HMS_REF_HSW |
                                       plan_reg.ref_sel == hms_pkg::HMS_REF_NONE);
  wire       start_ok   = homing_start & (state_reg != hms_pkg::HMS_ST_SEEK) &
                          (state_reg != hms_pkg::HMS_ST_CREEP);
  wire       seek_done  = (state_reg == hms_pkg::HMS_ST_SEEK) & ref_hit & ~plan_reg.use_index; // [RULE7]
  wire       creep_done = (state_reg == hms_pkg::HMS_ST_CREEP) & index_hit; // [RULE1] [RULE2] [RULE3] [RULE4]
  wire       here_done  = start_ok & plan_new.valid & ~plan_new.moves; // [RULE10]
  wire       home_now   = ~homing_abort & (seek_done | creep_done | here_done); // [RULE8] [RULE9]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      hms_pkg::HMS_ST_IDLE, hms_pkg::HMS_ST_DONE, hms_pkg::HMS_ST_FAULT: begin
        if (start_ok) begin
          if (!plan_new.valid) state_next = hms_pkg::HMS_ST_FAULT;
          else if (!plan_new.moves) state_next = hms_pkg::HMS_ST_DONE;
          else state_next = hms_pkg::HMS_ST_SEEK;
        end
      end
      hms_pkg::HMS_ST_SEEK: begin
        if (lim_fault) state_next = hms_pkg::HMS_ST_FAULT;
        else if (plan_reg.ref_sel == hms_pkg::HMS_REF_NONE) state_next = hms_pkg::HMS_ST_CREEP;
        else if (ref_hit) state_next = plan_reg.use_index ? hms_pkg::HMS_ST_CREEP : hms_pkg::HMS_ST_DONE;
      end
      hms_pkg::HMS_ST_CREEP: begin
        if (index_hit) state_next = hms_pkg::HMS_ST_DONE;
        else if (lim_fault) state_next = hms_pkg::HMS_ST_FAULT;
      end
      default: state_next = hms_pkg::HMS_ST_IDLE;
    endcase
    if (homing_abort) state_next = hms_pkg::HMS_ST_IDLE;
  end

  wire moving      = (state_next == hms_pkg::HMS_ST_SEEK) | (state_next == hms_pkg::HMS_ST_CREEP);
  wire dir_next    = start_ok ? plan_new.dir_pos : plan_reg.dir_pos;
  wire [31:0] pos_step = enc_dir_pos ? position + 32'h0000_0001 : position - 32'h0000_0001;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg      <= hms_pkg::HMS_ST_IDLE;
      plan_reg       <= '0;
      method_act_reg <= `HMS_METHOD_RST;
      seen_reg       <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (start_ok) begin
        plan_reg       <= plan_new;
        method_act_reg <= method_reg;
      end
      if (start_ok) seen_reg <= 1'b0;
      else if (state_reg == hms_pkg::HMS_ST_SEEK && ref_level) seen_reg <= 1'b1;
    end
  end

  // motion outputs follow the next state so they stop in the same edge as the home point
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      move_pos     <= 1'b0;
      move_neg     <= 1'b0;
      move_slow    <= 1'b0;
      homing_busy  <= 1'b0;
      homing_done  <= 1'b0;
      homing_error <= 1'b0;
      home_set     <= 1'b0;
      position     <= 32'h0000_0000;
    end else begin
      move_pos     <= moving & dir_next & ~home_now; // [RULE11]
      move_neg     <= moving & ~dir_next & ~home_now; // [RULE11]
      move_slow    <= state_next == hms_pkg::HMS_ST_CREEP;
      homing_busy  <= moving;
      homing_done  <= state_next == hms_pkg::HMS_ST_DONE;
      homing_error <= state_next == hms_pkg::HMS_ST_FAULT;
      home_set     <= home_now;
      // origin wins over an encoder step in the same cycle
      if (home_now) position <= 32'h0000_0000; // [RULE11]
      else if (enc_step) position <= pos_step;
    end
  end

  // object access: one-cycle acknowledge, unknown index or out-of-range method flags an error
  wire idx_touch  = obj_index == `HMS_IDX_TOUCH_CTRL;
  wire idx_method = obj_index == `HMS_IDX_METHOD;
  wire idx_status = obj_index == `HMS_IDX_STATUS;
  wire idx_pos    = obj_index == `HMS_IDX_POSITION;
  wire method_ok  = obj_wdata[7:0] <= `HMS_METHOD_MAX && obj_wdata[15:8] == 8'h00;
  wire wr_touch   = obj_sel & obj_wr & idx_touch;
  wire wr_method  = obj_sel & obj_wr & idx_method & method_ok;
  wire bad_access = ~(idx_touch | idx_method | idx_status | idx_pos) |
                    (obj_wr & (idx_status | idx_pos)) | (obj_wr & idx_method & ~method_ok);
  // each flag is widened before the shift so no bit is lost to a one-bit operand
  wire [31:0] status_word =
    (32'(homing_busy)  << `HMS_ST_BUSY_BIT) | (32'(homing_done) << `HMS_ST_DONE_BIT) |
    (32'(homing_error) << `HMS_ST_ERR_BIT)  | (32'(move_slow)   << `HMS_ST_SLOW_BIT) |
    (32'(move_pos)     << `HMS_ST_POS_BIT)  | (32'(move_neg)    << `HMS_ST_NEG_BIT);
  wire [31:0] rd_mux = idx_touch  ? {16'h0000, touch_ctrl_reg} :
                       idx_method ? {24'h000000, method_reg} :
                       idx_status ? status_word :
                       idx_pos    ? position : 32'h0000_0000;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      touch_ctrl_reg <= `HMS_TOUCH_CTRL_RST;
      method_reg     <= `HMS_METHOD_RST;
      obj_rdata      <= 32'h0000_0000;
      obj_ack        <= 1'b0;
      obj_err        <= 1'b0;
    end else begin
      if (wr_touch) touch_ctrl_reg <= obj_wdata;
      if (wr_method) method_reg <= obj_wdata[7:0];
      obj_ack   <= obj_sel;
      obj_err   <= obj_sel & bad_access;
      obj_rdata <= (obj_sel & ~obj_wr & ~bad_access) ? rd_mux : 32'h0000_0000;
    end
  end

  wire act_coinc = method_act_reg >= `HMS_CODE_COINC_LO && method_act_reg <= `HMS_CODE_COINC_HI;
  wire in_seek   = state_reg == hms_pkg::HMS_ST_SEEK;
  wire in_creep  = state_reg == hms_pkg::HMS_ST_CREEP;

  code1_dir_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE1]
    (in_seek && method_act_reg == 8'h01 && !homing_abort && !home_now) |=> move_neg && !move_pos)
    else $error("code 1 not moving negative");
  code2_dir_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE2]
    (in_seek && method_act_reg == 8'h02 && !homing_abort && !home_now) |=> move_pos && !move_neg)
    else $error("code 2 not moving positive");
  sw_fall_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE3]
    (in_creep && $past(in_seek) && (method_act_reg == 8'h05 || method_act_reg == 8'h0b))
    |-> $past(in_fall[`HMS_IN_HSW]))
    else $error("negative falling-edge codes left search without falling edge");
  sw_rise_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE4]
    (in_creep && (method_act_reg == 8'h04 || method_act_reg == 8'h0c) && $changed(state_reg))
    |-> $past(in_rise[`HMS_IN_HSW]) && move_slow)
    else $error("rising-edge code entered creep without rising edge");
  far_side_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE5]
    (in_creep && $past(in_seek) && (method_act_reg == 8'h09 || method_act_reg == 8'h0d)) |-> $past(seen_reg))
    else $error("far-side code accepted edge before crossing switch");
  far_dir_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE6]
    (homing_busy && method_act_reg == 8'h0e) |-> move_neg && !move_pos)
    else $error("code 14 not moving negative");
  coinc_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE7]
    (act_coinc && in_seek && ref_hit && !homing_abort) |=> home_set && !move_slow)
    else $error("coincident code did not home on switch edge");
  idx_neg_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE8]
    (in_creep && method_act_reg == `HMS_CODE_IDX_NEG && !home_now && !homing_abort && !lim_fault) |=> move_neg)
    else $error("code 33 not moving negative");
  idx_pos_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE9]
    (in_seek && method_act_reg == `HMS_CODE_IDX_POS && !homing_abort && !lim_fault) |=> in_creep ##0 move_pos)
    else $error("code 34 did not arm on index");
  here_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE10]
    (start_ok && method_reg == `HMS_CODE_HERE && !homing_abort) |=> home_set && position == 32'h0 && !homing_busy)
    else $error("code 35 did not home at once");
  stop_home_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE11]
    (home_set && !homing_start) |-> !move_pos && !move_neg && position == 32'h0 ##1 !move_pos && !move_neg)
    else $error("motion or count not stopped at home");
  index_home_a: assert property (@(posedge clk) disable iff (!rst_sync_n) // [RULE11]
    (in_creep && index_hit && !homing_abort) |=> home_set ##1 !home_set)
    else $error("index in creep did not give one home pulse");

  cov_index_home_c: cover property (@(posedge clk) disable iff (!rst_sync_n) in_creep ##1 home_set);
  cov_coinc_c: cover property (@(posedge clk) disable iff (!rst_sync_n) act_coinc && home_set);
  cov_fault_c: cover property (@(posedge clk) disable iff (!rst_sync_n) $rose(homing_error));
  cov_abort_c: cover property (@(posedge clk) disable iff (!rst_sync_n) homing_busy && homing_abort);
endmodule
`default_nettype wire

// >>> bench/hms_axis_model.sv
// axis model: encoder counts and index pulses that follow the motion commands
`timescale 1ns/1ns
`default_nettype none
module hms_axis_model (
  input  wire logic clk,
  input  wire logic move_pos,
  input  wire logic move_neg,
  input  wire logic move_slow,
  output var  logic enc_step,
  output var  logic enc_dir_pos,
  output var  logic enc_index
);
  logic [31:0] axis_pos;
  logic [2:0]  pace;
  initial begin
    axis_pos    = 32'h0000_0003;
    pace        = 3'h0;
    enc_step    = 1'b0;
    enc_dir_pos = 1'b0;
    enc_index   = 1'b0;
  end
  // counts land on the falling edge so the sequencer samples settled levels
  always @(negedge clk) begin
    enc_step = 1'b0;
    if (move_pos ^ move_neg) begin
      pace = pace + 3'h1;
      // creep is half the seek rate, so an index can never sneak in unseen
      if (pace > (move_slow ? 3'h3 : 3'h1)) begin
        pace        = 3'h0;
        axis_pos    = move_pos ? axis_pos + 32'h1 : axis_pos - 32'h1;
        enc_step    = 1'b1;
        enc_dir_pos = move_pos;
        // index high for one count in eight; a stalled axis leaves it standing
        enc_index   = (axis_pos[2:0] == 3'h0);
      end
    end
  end
endmodule
`default_nettype wire

// >>> bench/hms_sequencer_tb.sv
// self-checking testbench of the homing method sequencer
`include "hms_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module hms_sequencer_tb;
  logic        clk, rst_n, neg_limit, pos_limit, home_switch, homing_start, homing_abort;
  logic        obj_sel, obj_wr, obj_ack, obj_err, move_pos, move_neg, move_slow;
  logic        homing_busy, homing_done, homing_error, home_set, enc_step, enc_dir_pos, enc_index;
  logic [15:0] obj_index, obj_wdata;
  logic [31:0] obj_rdata, position, rd, seed;
  logic        er;
  int          miscompares, comparisons, model_pos, home_cnt, slow_seen;

  hms_sequencer hms_sequencer_i (.clk(clk), .rst_n(rst_n), .neg_limit(neg_limit), .pos_limit(pos_limit),
    .home_switch(home_switch), .enc_index(enc_index), .enc_step(enc_step), .enc_dir_pos(enc_dir_pos),
    .homing_start(homing_start), .homing_abort(homing_abort), .obj_sel(obj_sel), .obj_wr(obj_wr),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
    .obj_err(obj_err), .move_pos(move_pos), .move_neg(move_neg), .move_slow(move_slow),
    .homing_busy(homing_busy), .homing_done(homing_done), .homing_error(homing_error),
    .home_set(home_set), .position(position));
  hms_axis_model hms_axis_model_i (.clk(clk), .move_pos(move_pos), .move_neg(move_neg),
    .move_slow(move_slow), .enc_step(enc_step), .enc_dir_pos(enc_dir_pos), .enc_index(enc_index));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // steps are counted on the rising edge, design outputs on the falling edge
  always @(posedge clk) begin
    if (!rst_n) model_pos = 0;
    else if (enc_step === 1'b1) model_pos = model_pos + (enc_dir_pos ? 1 : -1);
  end
  always @(negedge clk) begin
    if (home_set === 1'b1) home_cnt++;
    if (move_slow === 1'b1) slow_seen = 1;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic int exp_dir(input int b);
    case (b)
      1, 4, 5, 11, 12, 13, 14, 33: return 2;
      2, 3, 6, 7, 8, 9, 10, 34: return 1;
      35: return 0;
      default: return 3;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic obj_io(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    obj_sel = 1'b1;
    obj_wr = wr;
    obj_index = idx;
    obj_wdata = wd;
    tick(1);
    // the answer stands for one cycle only, so it is taken before the strobe drops
    chk({31'h0, obj_ack}, 32'h1);
    rd = obj_rdata;
    er = obj_err;
    obj_sel = 1'b0;
    tick(1);
  endtask
  task automatic go(input logic [7:0] code);
    obj_io(1'b1, `HMS_IDX_METHOD, {8'h00, code});
    homing_start = 1'b1;
    tick(1);
    homing_start = 1'b0;
  endtask
  task automatic sw(input int which, input logic v);
    if (which == 0) neg_limit = v;
    else if (which == 1) pos_limit = v;
    else home_switch = v;
  endtask
  task automatic wait_home(input int lim);
    int n;
    n = 0;
    while (home_set !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    chk({31'h0, home_set}, 32'h1);
    chk({30'h0, move_pos, move_neg}, 32'h0);
    chk({30'h0, homing_busy, homing_done}, 32'h1);
    tick(3);
    chk(position, 32'h0);
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #(60000 * 50);
    miscompares++;
    report_and_stop();
  end

  initial begin
    int d, b, which, h0;
    logic rise, other;
    logic [15:0] tw;
    seed = 32'h8ce9a5d2;
    {rst_n, neg_limit, pos_limit, home_switch, homing_start, homing_abort} = 6'h00;
    {obj_sel, obj_wr, obj_index, obj_wdata} = 34'h0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    tick(3);
    obj_io(1'b0, `HMS_IDX_TOUCH_CTRL, 16'h0000);
    chk(rd, 32'h0);
    obj_io(1'b0, `HMS_IDX_METHOD, 16'h0000);
    chk(rd, 32'h0);
    tw = 16'(xs());
    obj_io(1'b1, `HMS_IDX_TOUCH_CTRL, tw);
    obj_io(1'b0, `HMS_IDX_TOUCH_CTRL, 16'h0000);
    chk(rd, {16'h0, tw});
    obj_io(1'b1, `HMS_IDX_METHOD, 16'h0024);
    chk({31'h0, er}, 32'h1);
    obj_io(1'b1, `HMS_IDX_STATUS, 16'h0001);
    chk({31'h0, er}, 32'h1);
    obj_io(1'b0, 16'h1234, 16'h0000);
    chk({31'h0, er}, 32'h1);
    // abort mid-search: motion stops and the count keeps every step taken
    go(8'h03);
    obj_io(1'b0, `HMS_IDX_STATUS, 16'h0000);
    chk(rd & 32'h31, 32'h11);
    tick(30);
    homing_abort = 1'b1;
    tick(1);
    homing_abort = 1'b0;
    tick(3);
    chk({30'h0, move_pos, move_neg}, 32'h0);
    obj_io(1'b0, `HMS_IDX_POSITION, 16'h0000);
    chk(rd, model_pos);
    chk(position, model_pos);
    for (int c = 0; c <= 35; c++) begin
      b = (c >= 17 && c <= 30) ? c - 16 : c;
      d = exp_dir(b);
      which = (b == 1) ? 0 : (b == 2) ? 1 : 2;
      rise = b inside {4, 6, 8, 9, 12, 13};
      other = b inside {9, 10, 13, 14};
      go(c[7:0]);
      chk({30'h0, move_pos, move_neg}, {30'h0, d == 1, d == 2});
      if (d == 3) begin
        chk({31'h0, homing_error}, 32'h1);
      end else if (d == 0) begin
        chk({31'h0, home_set}, 32'h1);
        tick(3);
        chk(position, 32'h0);
      end else if (b >= 33) begin
        tick(1);
        chk({31'h0, move_slow}, 32'h1);
        wait_home(100);
      end else begin
        h0 = home_cnt;
        slow_seen = 0;
        tick(20 + int'(xs() % 20));
        chk(home_cnt - h0, 32'h0);
        sw(which, 1'b1);
        if (!rise || other) begin
          tick(3);
          sw(which, 1'b0);
        end
        if (rise && other) begin
          tick(3);
          sw(which, 1'b1);
        end
        if (c <= 14) begin
          tick(2);
          chk({31'h0, move_slow}, 32'h1);
          wait_home(200);
        end else begin
          wait_home(4);
          chk(slow_seen, 32'h0);
        end
        {neg_limit, pos_limit, home_switch} = 3'h0;
        tick(6);
      end
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
